// file: can_rx_filter_and_tx_config.sv
// CAN node settings, receive acceptance, flow replies and error status
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Auto flow control on by default; accepted First Frame triggers a Flow Control reply.
// - Same enable gates CTS replies to transport-protocol RTS requests.
// - No Flow Control is sent while any monitoring mode is active.
// - Mask bit 1 means must match; mask bit 0 means ignored.
// - Frame accepted only if all masked identifier bits equal the filter.
// - Three-digit mask keeps the low 11 bits; top supplied bit dropped.
// - Short and long masks share one right-justified store.
// - Eight-digit mask drops three top bits, keeps 29.
// - Priority keeps five low bits as top of 29-bit transmit identifier.
// - Priority defaults to hex 18 and returns there on restore-defaults.
// - Receive-address command without argument restores mask and filter defaults.
// - Receive-address with an identifier sets mask and filter for exactly it.
// - An X digit clears its mask nibble, accepting any value there.
// - 29-bit receive-address alike; undone by bare receive-address or automatic receive.
// - Transmit and receive error counts kept; transmitter off above FF.
// - Input frequency reported as 500, 250, below 250 or none.
// - Silent watch sends no acknowledge while monitoring; default from a strap.
// - Response timeout scaled by 1 or 5, only for protocols 6 to C.
module can_rx_filter_and_tx_config #(
	parameter int MEAS_CYCLES = can_node_pkg::MEAS_CYCLES,
	parameter int ARG_CHARS = can_node_pkg::EXT_DIGITS
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Host command, argument characters rightmost in bits 7:0
	input wire logic cmd_valid_in,
	input wire can_node_pkg::cmd_type cmd_code_in,
	input wire logic [ARG_CHARS*8-1:0] cmd_arg_in,
	input wire logic [3:0] cmd_arg_len_in,
	output logic cmd_error_out,
	// Strap for silent watch default
	input wire logic prog_param_silent_default_in,
	// Monitoring and protocol state
	input wire logic monitor_active_in,
	input wire logic [3:0] protocol_in,
	input wire logic [7:0] response_timeout_in,
	// Received frame
	input wire logic rx_frame_valid_in,
	input wire logic [28:0] rx_id_in,
	input wire logic rx_first_frame_in,
	input wire logic rx_tp_rts_in,
	output logic rx_accept_out,
	output logic flow_reply_send_out,
	output logic tp_cts_send_out,
	// Transmit identifier
	input wire logic [23:0] header_set_in,
	output logic [28:0] tx_id_out,
	// Bus error events
	input wire logic tx_err_in,
	input wire logic tx_ok_in,
	input wire logic rx_err_in,
	input wire logic rx_ok_in,
	// Status
	output logic [7:0] tx_err_count_out,
	output logic [7:0] rx_err_count_out,
	output logic tx_off_out,
	output logic ack_enable_out,
	output logic tx_enable_out,
	output logic [10:0] timeout_scaled_out,
	output logic flow_reply_on_out,
	output logic silent_watch_out,
	output logic timeout_scale_five_out,
	// CAN input level for frequency class
	input wire logic can_rx_in,
	output can_node_pkg::freq_class_type freq_class_out
);
	typedef struct packed {
		logic strap_done;
		logic flow_on;
		logic silent;
		logic scale5;
		logic [4:0] prio;
		logic [28:0] mask;
		logic [28:0] filter;
		logic [8:0] tec;
		logic [7:0] rec;
		logic accept;
		logic fc_send;
		logic cts_send;
		logic cmd_err;
		logic [10:0] tmo;
	} cfg_state_type;

	cfg_state_type st_r, st_nxt;

	// Argument decode
	logic [3:0] nib[ARG_CHARS];
	logic nib_x[ARG_CHARS];
	logic nib_ok[ARG_CHARS];
	logic [31:0] arg_val;
	logic [31:0] arg_xbits;
	logic arg_hex_ok;
	logic arg_x_ok;
	logic any_x;

	// One decoder per argument character
	genvar gi;
	generate
		for (gi = 0; gi < ARG_CHARS; gi++) begin : g_dec
			hex_char_decode u_dec (
				.char_in(cmd_arg_in[gi*8 +: 8]),
				.nibble_out(nib[gi]),
				.is_x_out(nib_x[gi]),
				.ok_out(nib_ok[gi])
			);
		end
	endgenerate

	always_comb begin
		arg_val = 32'h0;
		arg_xbits = 32'h0;
		arg_hex_ok = 1'b1;
		arg_x_ok = 1'b1;
		any_x = 1'b0;
		for (int i = 0; i < ARG_CHARS; i++) begin
			if (4'(i) < cmd_arg_len_in) begin
				arg_val[i*4 +: 4] = nib[i];
				if (nib_x[i]) begin
					arg_xbits[i*4 +: 4] = 4'hf;
					any_x = 1'b1;
				end
				if (!nib_ok[i]) begin
					arg_x_ok = 1'b0;
				end
			end
		end
		// Plain hex excludes X digits
		if (any_x || !arg_x_ok) begin
			arg_hex_ok = 1'b0;
		end
	end

	// Coarse bus rate for the status report
	can_freq_meter #(
		.MEAS_CYCLES(MEAS_CYCLES)
	) u_freq (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.can_rx_in(can_rx_in),
		.freq_class_out(freq_class_out)
	);

	logic len_std;
	logic len_ext;
	logic tx_off;
	logic in_can_proto;
	// Restore clears the counts before this cycle's error events
	logic restore_now;
	logic [8:0] tec_base;
	logic [7:0] rec_base;
	logic off_base;

	assign len_std = cmd_arg_len_in == 4'(can_node_pkg::STD_DIGITS);
	assign len_ext = cmd_arg_len_in == 4'(can_node_pkg::EXT_DIGITS);
	// Bus off sticks until reset or restore-defaults
	assign tx_off = st_r.tec >= can_node_pkg::TEC_OFF_LEVEL;
	assign in_can_proto = protocol_in >= can_node_pkg::CAN_PROTO_FIRST &&
		protocol_in <= can_node_pkg::CAN_PROTO_LAST;
	assign restore_now = cmd_valid_in &&
		cmd_code_in == can_node_pkg::CMD_RESTORE_DEFAULTS;
	assign tec_base = restore_now ? 9'h000 : st_r.tec;
	assign rec_base = restore_now ? 8'h00 : st_r.rec;
	assign off_base = tec_base >= can_node_pkg::TEC_OFF_LEVEL;

	always_comb begin
		st_nxt = st_r;
		st_nxt.accept = 1'b0;
		st_nxt.fc_send = 1'b0;
		st_nxt.cts_send = 1'b0;
		st_nxt.cmd_err = 1'b0;

		// Silent default caught once after reset release
		if (!st_r.strap_done) begin
			st_nxt.strap_done = 1'b1;
			st_nxt.silent = prog_param_silent_default_in;
		end

		// Acceptance and automatic replies
		if (rx_frame_valid_in &&
			((rx_id_in ^ st_r.filter) & st_r.mask) == 29'h0) begin
			st_nxt.accept = 1'b1;
			// Monitoring blocks both replies whatever the enable
			if (st_r.flow_on && !monitor_active_in) begin
				st_nxt.fc_send = rx_first_frame_in;
				st_nxt.cts_send = rx_tp_rts_in;
			end
		end

		// Timeout scaling
		// Scale applies to CAN protocols only
		if (st_r.scale5 && in_can_proto) begin
			st_nxt.tmo = {3'h0, response_timeout_in} * can_node_pkg::SCALE_FIVE;
		end else begin
			st_nxt.tmo = {3'h0, response_timeout_in};
		end

		// Host commands
		if (cmd_valid_in) begin
			unique case (cmd_code_in)
				can_node_pkg::CMD_AUTO_FLOW_REPLY_OFF: begin
					st_nxt.flow_on = 1'b0;
				end
				can_node_pkg::CMD_AUTO_FLOW_REPLY_ON: begin
					st_nxt.flow_on = 1'b1;
				end
				can_node_pkg::CMD_ID_MASK_SET, can_node_pkg::CMD_ID_FILTER_SET: begin
					// X digits refused; only receive-address takes them
					if (arg_hex_ok && len_std) begin
						if (cmd_code_in == can_node_pkg::CMD_ID_MASK_SET) begin
							st_nxt.mask = arg_val[28:0] & can_node_pkg::STD_ID_MASK;
						end else begin
							st_nxt.filter = arg_val[28:0] & can_node_pkg::STD_ID_MASK;
						end
					end else if (arg_hex_ok && len_ext) begin
						if (cmd_code_in == can_node_pkg::CMD_ID_MASK_SET) begin
							st_nxt.mask = arg_val[28:0];
						end else begin
							st_nxt.filter = arg_val[28:0];
						end
					end else begin
						st_nxt.cmd_err = 1'b1;
					end
				end
				can_node_pkg::CMD_TX_PRIORITY_SET: begin
					if (arg_hex_ok && cmd_arg_len_in == 4'h2) begin
						st_nxt.prio = arg_val[4:0];
					end else begin
						st_nxt.cmd_err = 1'b1;
					end
				end
				can_node_pkg::CMD_SINGLE_RX_ID_SET: begin
					// No argument undoes any single-address setting
					if (cmd_arg_len_in == 4'h0) begin
						st_nxt.mask = can_node_pkg::MASK_DEFAULT;
						st_nxt.filter = can_node_pkg::FILTER_DEFAULT;
					end else if (arg_x_ok && len_std) begin
						st_nxt.mask = can_node_pkg::STD_ID_MASK & ~arg_xbits[28:0];
						st_nxt.filter = arg_val[28:0] & can_node_pkg::STD_ID_MASK;
					end else if (arg_x_ok && len_ext) begin
						st_nxt.mask = can_node_pkg::EXT_ID_MASK & ~arg_xbits[28:0];
						st_nxt.filter = arg_val[28:0];
					end else begin
						st_nxt.cmd_err = 1'b1;
					end
				end
				can_node_pkg::CMD_AUTOMATIC_RECEIVE: begin
					st_nxt.mask = can_node_pkg::MASK_DEFAULT;
					st_nxt.filter = can_node_pkg::FILTER_DEFAULT;
				end
				can_node_pkg::CMD_SILENT_WATCH_OFF: begin
					st_nxt.silent = 1'b0;
				end
				can_node_pkg::CMD_SILENT_WATCH_ON: begin
					st_nxt.silent = 1'b1;
				end
				can_node_pkg::CMD_TIMEOUT_SCALE_ONE: begin
					st_nxt.scale5 = 1'b0;
				end
				can_node_pkg::CMD_TIMEOUT_SCALE_FIVE: begin
					st_nxt.scale5 = 1'b1;
				end
				can_node_pkg::CMD_RESTORE_DEFAULTS: begin
					st_nxt.flow_on = can_node_pkg::FLOW_DEFAULT;
					st_nxt.silent = prog_param_silent_default_in;
					st_nxt.scale5 = can_node_pkg::SCALE5_DEFAULT;
					st_nxt.prio = can_node_pkg::PRIO_DEFAULT;
					st_nxt.mask = can_node_pkg::MASK_DEFAULT;
					st_nxt.filter = can_node_pkg::FILTER_DEFAULT;
					// Counts cleared through restore_now
				end
				default: begin
					st_nxt.cmd_err = 1'b1;
				end
			endcase
		end

		// Error counters, cleared first on restore so no event is lost
		if (tx_err_in && !off_base) begin
			st_nxt.tec = tec_base + can_node_pkg::TEC_STEP;
			if (st_nxt.tec > can_node_pkg::TEC_OFF_LEVEL) begin
				st_nxt.tec = can_node_pkg::TEC_OFF_LEVEL;
			end
		end else if (tx_ok_in && !off_base && tec_base != 9'h000) begin
			st_nxt.tec = tec_base - 9'h001;
		end else begin
			st_nxt.tec = tec_base;
		end
		if (rx_err_in && rec_base != can_node_pkg::REC_MAX) begin
			st_nxt.rec = rec_base + 8'h01;
		end else if (rx_ok_in && !rx_err_in && rec_base != 8'h00) begin
			st_nxt.rec = rec_base - 8'h01;
		end else begin
			st_nxt.rec = rec_base;
		end
	end

	// Silent starts on so nothing is acknowledged while monitoring before the strap is read
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '{
				strap_done: 1'b0,
				flow_on: can_node_pkg::FLOW_DEFAULT,
				silent: 1'b1,
				scale5: can_node_pkg::SCALE5_DEFAULT,
				prio: can_node_pkg::PRIO_DEFAULT,
				mask: can_node_pkg::MASK_DEFAULT,
				filter: can_node_pkg::FILTER_DEFAULT,
				tec: 9'h000,
				rec: 8'h00,
				accept: 1'b0,
				fc_send: 1'b0,
				cts_send: 1'b0,
				cmd_err: 1'b0,
				tmo: 11'h000
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign rx_accept_out = st_r.accept;
	assign flow_reply_send_out = st_r.fc_send;
	assign tp_cts_send_out = st_r.cts_send;
	assign cmd_error_out = st_r.cmd_err;
	assign tx_id_out = {st_r.prio, header_set_in};
	assign tx_err_count_out = tx_off ? 8'hff : st_r.tec[7:0];
	assign rx_err_count_out = st_r.rec;
	assign tx_off_out = tx_off;
	assign ack_enable_out = !tx_off && !(monitor_active_in && st_r.silent);
	assign tx_enable_out = !tx_off && !(monitor_active_in && st_r.silent);
	assign timeout_scaled_out = st_r.tmo;
	assign flow_reply_on_out = st_r.flow_on;
	assign silent_watch_out = st_r.silent;
	assign timeout_scale_five_out = st_r.scale5;
endmodule : can_rx_filter_and_tx_config
`default_nettype wire

// file: can_node_pkg.sv
// Shared constants and types for the CAN node configuration block
package can_node_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_KHZ = 125000;

	// Frequency measurement window
	localparam int MEAS_TIME_MS = 300;
	localparam int MEAS_CYCLES = MEAS_TIME_MS * CLK_KHZ;

	// Edge spacing limits between frequency classes
	localparam int FAST_LIMIT_NS = 3000;
	localparam int SLOW_LIMIT_NS = 6000;
	localparam int FAST_LIMIT_CYC = FAST_LIMIT_NS / CLK_PERIOD_NS;
	localparam int SLOW_LIMIT_CYC = SLOW_LIMIT_NS / CLK_PERIOD_NS;

	// Identifier layout
	localparam int ID_W = 29;
	localparam int STD_ID_W = 11;
	localparam int HDR_W = 24;
	localparam int PRIO_W = 5;
	localparam logic [28:0] STD_ID_MASK = 29'h00007ff;
	localparam logic [28:0] EXT_ID_MASK = 29'h1fffffff;
	localparam int STD_DIGITS = 3;
	localparam int EXT_DIGITS = 8;

	// Values after reset or restore-defaults
	localparam logic [4:0] PRIO_DEFAULT = 5'h18;
	localparam logic [28:0] MASK_DEFAULT = 29'h0000000;
	localparam logic [28:0] FILTER_DEFAULT = 29'h0000000;
	localparam logic FLOW_DEFAULT = 1'b1;
	localparam logic SCALE5_DEFAULT = 1'b0;

	// Error counters
	localparam logic [8:0] TEC_OFF_LEVEL = 9'h100;
	localparam logic [8:0] TEC_STEP = 9'h008;
	localparam logic [7:0] REC_MAX = 8'hff;

	// Timeout scaling
	localparam logic [3:0] CAN_PROTO_FIRST = 4'h6;
	localparam logic [3:0] CAN_PROTO_LAST = 4'hc;
	localparam logic [10:0] SCALE_FIVE = 11'h005;

	typedef enum logic [3:0] {
		CMD_AUTO_FLOW_REPLY_OFF,
		CMD_AUTO_FLOW_REPLY_ON,
		CMD_ID_MASK_SET,
		CMD_ID_FILTER_SET,
		CMD_TX_PRIORITY_SET,
		CMD_SINGLE_RX_ID_SET,
		CMD_AUTOMATIC_RECEIVE,
		CMD_SILENT_WATCH_OFF,
		CMD_SILENT_WATCH_ON,
		CMD_TIMEOUT_SCALE_ONE,
		CMD_TIMEOUT_SCALE_FIVE,
		CMD_RESTORE_DEFAULTS
	} cmd_type;

	typedef enum logic [1:0] {
		FREQ_NONE,
		FREQ_BELOW_250,
		FREQ_250,
		FREQ_500
	} freq_class_type;

endpackage : can_node_pkg

// file: hex_char_decode.sv
// ASCII hexadecimal argument character to nibble
`timescale 1ns/1ns
`default_nettype none
module hex_char_decode (
	// Character
	input wire logic [7:0] char_in,
	// Decoded value
	output logic [3:0] nibble_out,
	output logic is_x_out,
	output logic ok_out
);
	always_comb begin
		nibble_out = 4'h0;
		is_x_out = 1'b0;
		ok_out = 1'b1;
		if (char_in >= 8'h30 && char_in <= 8'h39) begin
			nibble_out = 4'(char_in - 8'h30);
		end else if (char_in >= 8'h41 && char_in <= 8'h46) begin
			nibble_out = 4'(char_in - 8'h37);
		end else if (char_in >= 8'h61 && char_in <= 8'h66) begin
			nibble_out = 4'(char_in - 8'h57);
		end else if (char_in == 8'h58 || char_in == 8'h78) begin
			is_x_out = 1'b1;
		end else begin
			ok_out = 1'b0;
		end
	end
endmodule : hex_char_decode
`default_nettype wire

// file: can_freq_meter.sv
// Coarse CAN input frequency classifier from shortest edge spacing
`timescale 1ns/1ns
`default_nettype none
module can_freq_meter #(
	parameter int MEAS_CYCLES = can_node_pkg::MEAS_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// CAN input level
	input wire logic can_rx_in,
	// Result
	output can_node_pkg::freq_class_type freq_class_out
);
	typedef struct packed {
		logic prev;
		logic seen;
		logic [31:0] win;
		logic [15:0] gap;
		logic [15:0] min_gap;
		can_node_pkg::freq_class_type cls;
	} meter_state_type;

	meter_state_type st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = can_rx_in;
		if (st_r.gap != 16'hffff) begin
			st_nxt.gap = st_r.gap + 16'h0001;
		end
		if (can_rx_in != st_r.prev) begin
			st_nxt.gap = 16'h0001;
			if (st_r.seen && st_r.gap < st_r.min_gap) begin
				st_nxt.min_gap = st_r.gap;
			end
			st_nxt.seen = 1'b1;
		end
		if (st_r.win == 32'(MEAS_CYCLES - 1)) begin
			st_nxt.win = 32'h0;
			st_nxt.seen = 1'b0;
			st_nxt.min_gap = 16'hffff;
			if (!st_r.seen) begin
				st_nxt.cls = can_node_pkg::FREQ_NONE;
			end else if (st_r.min_gap < 16'(can_node_pkg::FAST_LIMIT_CYC)) begin
				st_nxt.cls = can_node_pkg::FREQ_500;
			end else if (st_r.min_gap < 16'(can_node_pkg::SLOW_LIMIT_CYC)) begin
				st_nxt.cls = can_node_pkg::FREQ_250;
			end else begin
				st_nxt.cls = can_node_pkg::FREQ_BELOW_250;
			end
		end else begin
			st_nxt.win = st_r.win + 32'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '{prev: 1'b1, seen: 1'b0, win: 32'h0, gap: 16'h0,
				min_gap: 16'hffff, cls: can_node_pkg::FREQ_NONE};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign freq_class_out = st_r.cls;
endmodule : can_freq_meter
`default_nettype wire

// file: can_cfg_chk.sv
// Assertion checker for the CAN node settings block
`timescale 1ns/1ns
`default_nettype none
module can_cfg_chk (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Inputs watched
	input wire logic cmd_valid_in,
	input wire logic monitor_active_in,
	input wire logic [3:0] protocol_in,
	input wire logic [7:0] response_timeout_in,
	input wire logic rx_frame_valid_in,
	input wire logic rx_first_frame_in,
	input wire logic rx_tp_rts_in,
	input wire logic [23:0] header_set_in,
	input wire logic tx_err_in,
	input wire logic tx_ok_in,
	input wire logic rx_err_in,
	// Outputs watched
	input wire logic rx_accept_out,
	input wire logic flow_reply_send_out,
	input wire logic tp_cts_send_out,
	input wire logic [28:0] tx_id_out,
	input wire logic [7:0] tx_err_count_out,
	input wire logic [7:0] rx_err_count_out,
	input wire logic tx_off_out,
	input wire logic ack_enable_out,
	input wire logic tx_enable_out,
	input wire logic [10:0] timeout_scaled_out,
	input wire logic flow_reply_on_out,
	input wire logic silent_watch_out,
	input wire logic timeout_scale_five_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic scl_w = timeout_scale_five_out && protocol_in >= 4'h6 && protocol_in <= 4'hc;
	wire logic [10:0] exp_w = scl_w ? {3'h0, response_timeout_in} * 11'h005
		: {3'h0, response_timeout_in};
	fc_mon_a: assert property (
		rx_frame_valid_in && monitor_active_in |=> !flow_reply_send_out && !tp_cts_send_out)
		else $error("reply sent while monitoring");
	fc_on_a: assert property (
		rx_frame_valid_in && rx_first_frame_in && flow_reply_on_out && !monitor_active_in
		|=> flow_reply_send_out == rx_accept_out) else $error("flow reply wrong");
	fc_off_a: assert property (
		rx_frame_valid_in && !flow_reply_on_out |=> !flow_reply_send_out && !tp_cts_send_out)
		else $error("reply sent while disabled");
	cts_on_a: assert property (
		rx_frame_valid_in && rx_tp_rts_in && flow_reply_on_out && !monitor_active_in
		|=> tp_cts_send_out == rx_accept_out) else $error("cts reply wrong");
	tx_id_a: assert property (tx_id_out[23:0] == header_set_in)
		else $error("tx id low bits wrong");
	prio_hold_a: assert property (!cmd_valid_in |=> $stable(tx_id_out[28:24]))
		else $error("priority changed");
	bus_off_a: assert property (
		tx_off_out |-> tx_err_count_out == 8'hff && !tx_enable_out && !ack_enable_out)
		else $error("bus off status wrong");
	tec_step_a: assert property (
		tx_err_in && !tx_ok_in && !cmd_valid_in && tx_err_count_out < 8'hf8
		|=> tx_err_count_out == $past(tx_err_count_out) + 8'h08) else $error("tec step");
	rec_step_a: assert property (
		rx_err_in && !cmd_valid_in && rx_err_count_out < 8'hff
		|=> rx_err_count_out == $past(rx_err_count_out) + 8'h01) else $error("rec step");
	ack_gate_a: assert property (
		!tx_off_out |-> ack_enable_out == !(monitor_active_in && silent_watch_out))
		else $error("ack enable wrong");
	scale_a: assert property (
		!cmd_valid_in |=> timeout_scaled_out == $past(exp_w)) else $error("timeout scale");
	cover property (flow_reply_send_out);
	cover property (tp_cts_send_out);
	cover property (tx_off_out);
	cover property (scl_w && response_timeout_in != 8'h00);
endmodule : can_cfg_chk
bind can_rx_filter_and_tx_config can_cfg_chk chk (.*);
`default_nettype wire

// file: can_ecu_model.sv
// Behavioural model of the bus nodes sending frames and bus level
`timescale 1ns/1ns
`default_nettype none
module can_ecu_model (
	// Clock and bus activity
	input wire logic core_clk_in,
	input wire logic bus_on_in,
	input wire logic [10:0] half_in,
	// Bus level and received frame
	output logic can_rx_out,
	output logic rx_frame_valid_out,
	output logic [28:0] rx_id_out,
	output logic rx_first_frame_out,
	output logic rx_tp_rts_out
);
	logic [10:0] cnt_r = 11'h000;
	initial begin
		can_rx_out = 1'b1;
		rx_frame_valid_out = 1'b0;
		rx_id_out = 29'h0;
		rx_first_frame_out = 1'b0;
		rx_tp_rts_out = 1'b0;
	end
	// Recessive when idle, else toggles every half_in cycles
	always @(negedge core_clk_in) begin
		cnt_r <= (bus_on_in && cnt_r + 11'h001 < half_in) ? cnt_r + 11'h001 : 11'h000;
		if (!bus_on_in)
			can_rx_out <= 1'b1;
		else if (cnt_r + 11'h001 >= half_in)
			can_rx_out <= ~can_rx_out;
	end
	// One frame; qualifiers scrambled once released
	task automatic send(input logic [28:0] id, input logic ff, input logic rts);
		@(negedge core_clk_in);
		rx_frame_valid_out = 1'b1;
		rx_id_out = id;
		rx_first_frame_out = ff;
		rx_tp_rts_out = rts;
		@(negedge core_clk_in);
		rx_frame_valid_out = 1'b0;
		rx_id_out = ~id;
		rx_first_frame_out = ~ff;
		rx_tp_rts_out = ~rts;
	endtask : send
endmodule : can_ecu_model
`default_nettype wire

// file: tb_can_rx_filter_and_tx_config.sv
// Self-checking testbench for the CAN node settings block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_can_rx_filter_and_tx_config;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic cmd_valid_in = 1'b0;
	can_node_pkg::cmd_type cmd_code_in = can_node_pkg::CMD_AUTOMATIC_RECEIVE;
	logic [63:0] cmd_arg_in = 64'h0;
	logic [3:0] cmd_arg_len_in = 4'h0;
	logic prog_param_silent_default_in = 1'b1;
	logic monitor_active_in = 1'b0;
	logic [3:0] protocol_in = 4'h6;
	logic [7:0] response_timeout_in = 8'h00;
	logic [23:0] header_set_in = 24'h0;
	logic tx_err_in = 1'b0, tx_ok_in = 1'b0, rx_err_in = 1'b0, rx_ok_in = 1'b0;
	logic bus_on = 1'b0;
	logic [10:0] half = 11'h0fa;
	wire logic rx_frame_valid_in, rx_first_frame_in, rx_tp_rts_in, can_rx_in;
	wire logic [28:0] rx_id_in, tx_id_out;
	wire logic cmd_error_out, rx_accept_out, flow_reply_send_out, tp_cts_send_out, tx_off_out;
	wire logic ack_enable_out, tx_enable_out, flow_reply_on_out, silent_watch_out;
	wire logic timeout_scale_five_out;
	wire logic [7:0] tx_err_count_out, rx_err_count_out;
	wire logic [10:0] timeout_scaled_out;
	wire can_node_pkg::freq_class_type freq_class_out;
	int mismatches = 0;
	int samples_checked = 0;
	can_rx_filter_and_tx_config #(.MEAS_CYCLES(2000), .ARG_CHARS(8)) dut (.*);
	can_ecu_model ecu (.core_clk_in(core_clk_in), .bus_on_in(bus_on), .half_in(half),
		.can_rx_out(can_rx_in), .rx_frame_valid_out(rx_frame_valid_in), .rx_id_out(rx_id_in),
		.rx_first_frame_out(rx_first_frame_in), .rx_tp_rts_out(rx_tp_rts_in));
	initial forever #4 core_clk_in = ~core_clk_in;
	function automatic logic acc(input logic [28:0] i, input logic [28:0] m, input logic [28:0] f);
		return ((i ^ f) & m) == 29'h0;
	endfunction : acc
	function automatic logic [10:0] tmo(input logic [7:0] t, input logic [3:0] p, input logic s);
		return (s && p >= 4'h6 && p <= 4'hc) ? {3'h0, t} * 11'h005 : {3'h0, t};
	endfunction : tmo
	task automatic cmd(input can_node_pkg::cmd_type c, input logic [63:0] a, input logic [3:0] n,
		input logic e);
		@(negedge core_clk_in);
		cmd_valid_in = 1'b1;
		cmd_code_in = c;
		cmd_arg_in = a;
		cmd_arg_len_in = n;
		@(negedge core_clk_in);
		cmd_valid_in = 1'b0;
		`CHK("cmd_error", e, cmd_error_out)
	endtask : cmd
	task automatic frm(input logic [28:0] i, input logic ff, input logic rts, input logic a,
		input logic f, input logic c);
		ecu.send(i, ff, rts);
		`CHK("accept", a, rx_accept_out)
		`CHK("flow_reply", f, flow_reply_send_out)
		`CHK("tp_cts", c, tp_cts_send_out)
	endtask : frm
	task automatic rnd(input logic [28:0] m, input logic [28:0] f, input logic [28:0] w);
		logic [28:0] id;
		repeat (12) begin
			id = 29'($urandom) & w;
			if ($urandom % 2)
				id = (id & ~m) | (f & m);
			frm(id, 1'b0, 1'b0, acc(id, m, f), 1'b0, 1'b0);
		end
	endtask : rnd
	task automatic hold(ref logic s, input int n);
		@(negedge core_clk_in);
		s = 1'b1;
		repeat (n) @(negedge core_clk_in);
		s = 1'b0;
	endtask : hold
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (100000) @(posedge core_clk_in);
		mismatches++;
		summarize();
	end
	initial begin
		void'($urandom(32'h1ba3));
		repeat (6) @(posedge core_clk_in);
		@(negedge core_clk_in) rst_b_in = 1'b1;
		@(negedge core_clk_in);
		`CHK("prio", 5'h18, tx_id_out[28:24])
		`CHK("flow_on", 1'b1, flow_reply_on_out)
		`CHK("silent", 1'b1, silent_watch_out)
		`CHK("scale5", 1'b0, timeout_scale_five_out)
		rnd(29'h0, 29'h0, 29'h1fffffff);
		cmd(can_node_pkg::CMD_ID_MASK_SET, "FFF", 4'h3, 1'b0);
		cmd(can_node_pkg::CMD_ID_FILTER_SET, "7E8", 4'h3, 1'b0);
		rnd(29'h7ff, 29'h7e8, 29'h1fffffff);
		cmd(can_node_pkg::CMD_ID_MASK_SET, "000007FF", 4'h8, 1'b0);
		rnd(29'h7ff, 29'h7e8, 29'h1fffffff);
		cmd(can_node_pkg::CMD_ID_MASK_SET, "FFFFFFFF", 4'h8, 1'b0);
		cmd(can_node_pkg::CMD_ID_FILTER_SET, "E8DAF110", 4'h8, 1'b0);
		cmd(can_node_pkg::CMD_ID_MASK_SET, "G00", 4'h3, 1'b1);
		rnd(29'h1fffffff, 29'h08daf110, 29'h1fffffff);
		cmd(can_node_pkg::CMD_SINGLE_RX_ID_SET, "7EX", 4'h3, 1'b0);
		rnd(29'h7f0, 29'h7e0, 29'h7ff);
		cmd(can_node_pkg::CMD_SINGLE_RX_ID_SET, 64'h0, 4'h0, 1'b0);
		rnd(29'h0, 29'h0, 29'h1fffffff);
		cmd(can_node_pkg::CMD_SINGLE_RX_ID_SET, "18DAF1XX", 4'h8, 1'b0);
		rnd(29'h1fffff00, 29'h18daf100, 29'h1fffffff);
		cmd(can_node_pkg::CMD_AUTOMATIC_RECEIVE, 64'h0, 4'h0, 1'b0);
		rnd(29'h0, 29'h0, 29'h1fffffff);
		frm(29'h7e8, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		frm(29'h7e8, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		monitor_active_in = 1'b1;
		frm(29'h7e8, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		frm(29'h7e8, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		monitor_active_in = 1'b0;
		cmd(can_node_pkg::CMD_AUTO_FLOW_REPLY_OFF, 64'h0, 4'h0, 1'b0);
		frm(29'h7e8, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		frm(29'h7e8, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		cmd(can_node_pkg::CMD_AUTO_FLOW_REPLY_ON, 64'h0, 4'h0, 1'b0);
		frm(29'h123, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		header_set_in = 24'($urandom);
		cmd(can_node_pkg::CMD_TX_PRIORITY_SET, "A5", 4'h2, 1'b0);
		`CHK("tx_id", {5'h05, header_set_in}, tx_id_out)
		cmd(can_node_pkg::CMD_TX_PRIORITY_SET, "1F", 4'h2, 1'b0);
		`CHK("prio", 5'h1f, tx_id_out[28:24])
		hold(rx_err_in, 3);
		hold(rx_ok_in, 1);
		`CHK("rec", 8'h02, rx_err_count_out)
		hold(tx_err_in, 16);
		hold(tx_ok_in, 1);
		`CHK("tec", 8'h7f, tx_err_count_out)
		hold(tx_err_in, 17);
		`CHK("tx_off", 1'b1, tx_off_out)
		`CHK("tx_en", 1'b0, tx_enable_out)
		prog_param_silent_default_in = 1'b0;
		cmd(can_node_pkg::CMD_RESTORE_DEFAULTS, 64'h0, 4'h0, 1'b0);
		`CHK("prio", 5'h18, tx_id_out[28:24])
		`CHK("tec", 8'h00, tx_err_count_out)
		`CHK("silent", 1'b0, silent_watch_out)
		monitor_active_in = 1'b1;
		cmd(can_node_pkg::CMD_SILENT_WATCH_ON, 64'h0, 4'h0, 1'b0);
		`CHK("ack", 1'b0, ack_enable_out)
		`CHK("tx_en", 1'b0, tx_enable_out)
		cmd(can_node_pkg::CMD_SILENT_WATCH_OFF, 64'h0, 4'h0, 1'b0);
		`CHK("ack", 1'b1, ack_enable_out)
		`CHK("tx_en", 1'b1, tx_enable_out)
		monitor_active_in = 1'b0;
		for (int s = 1; s >= 0; s--) begin
			if (s == 1)
				cmd(can_node_pkg::CMD_TIMEOUT_SCALE_FIVE, 64'h0, 4'h0, 1'b0);
			else
				cmd(can_node_pkg::CMD_TIMEOUT_SCALE_ONE, 64'h0, 4'h0, 1'b0);
			for (int p = 0; p < 16; p++) begin
				@(negedge core_clk_in);
				protocol_in = p[3:0];
				response_timeout_in = 8'($urandom);
				@(negedge core_clk_in);
				`CHK("timeout", tmo(response_timeout_in, protocol_in, s[0]), timeout_scaled_out)
			end
		end
		for (int k = 0; k < 4; k++) begin
			bus_on = k < 3;
			half = 11'h0fa << k;
			repeat (4500) @(negedge core_clk_in);
			`CHK("freq", can_node_pkg::freq_class_type'(3 - k), freq_class_out)
		end
		cmd(can_node_pkg::CMD_TX_PRIORITY_SET, "0C", 4'h2, 1'b0);
		`CHK("prio", 5'h0c, tx_id_out[28:24])
		// Mid-run reset with the strap low: silent must follow the strap
		@(negedge core_clk_in) rst_b_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		@(negedge core_clk_in);
		`CHK("silent", 1'b0, silent_watch_out)
		`CHK("prio", 5'h18, tx_id_out[28:24])
		`CHK("flow_on", 1'b1, flow_reply_on_out)
		summarize();
	end
endmodule : tb_can_rx_filter_and_tx_config
`default_nettype wire
